// file: verilog/ecc_map.vh
`ifndef ECC_MAP_VH
`define ECC_MAP_VH
// ************************************************************
// timing of the generated serial clocks
// ************************************************************
`define ECC_BIT_DIV       75
`define ECC_BIT_HIGH      37
`define ECC_FRAME_DIV     2400
`define ECC_WORD_BITS     8
// ************************************************************
// register offsets
// ************************************************************
`define ECC_REG_CTRL      4'h0
`define ECC_REG_STATUS    4'h1
`define ECC_REG_LAST      4'h2
// ************************************************************
// field positions and codes
// ************************************************************
`define ECC_CTRL_EXT_BIT  0
`define ECC_ST_CLIP_BIT   0
`define ECC_ST_THRU_BIT   1
`define ECC_ST_HDIS_BIT   2
`define ECC_ST_OVR_BIT    3
`define ECC_ST_HACT_BIT   4
`define ECC_MIN_POS_CODE  8'hFF
`define ECC_MIN_NEG_CODE  8'h7F
`define ECC_CLIP_MAG      7'h0F
`endif

// file: verilog/ecc_ctrl.v
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "ecc_map.vh"

module ecc_ctrl #(
  parameter BIT_DIV   = `ECC_BIT_DIV,
  parameter BIT_HIGH  = `ECC_BIT_HIGH,
  parameter FRAME_DIV = `ECC_FRAME_DIV
) (
  input  wire       sys_clk,              // basic clock
  input  wire       nrst,                 // async reset, active low
  input  wire [3:0] addr,                 // register address
  input  wire [7:0] wr_data,              // register write data
  input  wire       wr_en,                // write strobe
  input  wire       rd_en,                // read strobe
  output reg  [7:0] rd_data_q,            // read data, cycle after rd_en
  input  wire       center_clip_enable,   // async control pin
  input  wire       through_mode_select,  // async control pin
  input  wire       howl_detect_disable,  // async control pin
  input  wire       latch_strobe_n,       // control latch strobe, active low
  input  wire       ext_bit_clock,        // external bit clock
  input  wire       ext_frame_sync,       // external frame sync
  input  wire       send_input,           // serial pcm in
  output reg        send_output_q,        // serial pcm out
  output reg        send_output_oe_q,     // high while send_output drives
  output reg        bit_clock_output_q,   // 256 kHz bit clock
  output reg        frame_sync_output_q,  // 8 kHz frame sync
  output reg        howl_detect_active_q, // enables the howling detector
  output wire       master_clock_output   // buffered basic clock
);

  // ************************************************************
  // synchronisers
  // ************************************************************
  reg [1:0] ctl_clip_s, ctl_thru_s, ctl_hdis_s, ctl_stb_s;
  reg [1:0] bclk_s, fsync_s, sin_s;
  reg       stb_prev_q, bclk_prev_q;

  // every pin here is asynchronous to the basic clock, so each one passes
  // two flops first; this costs two cycles of latency, which is tiny beside
  // a bit time, and keeps metastability out of the edge detectors below
  // two flops per pin; only the second stage is read
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_clip_s  <= 2'h0;
      ctl_thru_s  <= 2'h0;
      ctl_hdis_s  <= 2'h0;
      ctl_stb_s   <= 2'h3;
      bclk_s      <= 2'h0;
      fsync_s     <= 2'h0;
      sin_s       <= 2'h0;
      stb_prev_q  <= 1'b1;
      bclk_prev_q <= 1'b0;
    end else begin
      ctl_clip_s  <= {ctl_clip_s[0], center_clip_enable};
      ctl_thru_s  <= {ctl_thru_s[0], through_mode_select};
      ctl_hdis_s  <= {ctl_hdis_s[0], howl_detect_disable};
      ctl_stb_s   <= {ctl_stb_s[0], latch_strobe_n};
      bclk_s      <= {bclk_s[0], ext_bit_clock};
      fsync_s     <= {fsync_s[0], ext_frame_sync};
      sin_s       <= {sin_s[0], send_input};
      stb_prev_q  <= ctl_stb_s[1];
      bclk_prev_q <= bclk_s[1];
    end
  end

  // ************************************************************
  // control latch
  // ************************************************************
  reg  clip_q, thru_q, hdis_q;
  wire stb_fall = stb_prev_q & ~ctl_stb_s[1];

  // the strobe edge is found on the synchronised copy, so the captured pin
  // values are the ones seen two cycles after the pins themselves; a pin
  // that moves in the same cycle as the strobe may land either way
  // pins may move at any time; the block only ever sees the captured copy
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clip_q               <= 1'b0;
      thru_q               <= 1'b0;
      hdis_q               <= 1'b0;
      howl_detect_active_q <= 1'b1;
    end else if (stb_fall) begin
      clip_q               <= ctl_clip_s[1];
      thru_q               <= ctl_thru_s[1];
      hdis_q               <= ctl_hdis_s[1];
      howl_detect_active_q <= ~ctl_hdis_s[1];
    end
  end

  // ************************************************************
  // clock generation
  // ************************************************************
  reg [6:0]  bit_cnt_q;
  reg [11:0] frm_cnt_q;

  // the bit clock is high for BIT_HIGH counts of BIT_DIV, so at an odd
  // divisor the low phase is one basic clock longer than the high phase;
  // the frame divider must be a whole multiple of the bit divider, or the
  // sync pulse would drift against the bit clock from frame to frame
  // both dividers restart together so sync lines up with bit clock edges
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q           <= 7'h00;
      frm_cnt_q           <= 12'h000;
      bit_clock_output_q  <= 1'b0;
      frame_sync_output_q <= 1'b0;
    end else begin
      bit_cnt_q <= (bit_cnt_q == BIT_DIV - 1) ? 7'h00 : bit_cnt_q + 7'h01;
      frm_cnt_q <= (frm_cnt_q == FRAME_DIV - 1) ? 12'h000 : frm_cnt_q + 12'h001;
      bit_clock_output_q  <= (bit_cnt_q < BIT_HIGH);
      frame_sync_output_q <= (frm_cnt_q < BIT_DIV);
    end
  end

  // cascaded chips take their clock from here, so only one oscillator is needed
  // the basic clock cannot pass a flop and stay the basic clock
  assign master_clock_output = sys_clk;

  // ************************************************************
  // timing source select
  // ************************************************************
  reg  ext_sel_q;
  wire int_rise = (bit_cnt_q == 7'h00);
  wire int_fall = (bit_cnt_q == BIT_HIGH);
  wire ext_rise = bclk_s[1] & ~bclk_prev_q;
  wire ext_fall = ~bclk_s[1] & bclk_prev_q;
  // internal edges come straight from the divider count; external ones come
  // from the synchronised link clock, so they trail the pin by two cycles
  // external timing is for slower basic clocks, where the divided rates drift
  wire launch   = ext_sel_q ? ext_rise : int_rise;
  wire sample   = ext_sel_q ? ext_fall : int_fall;
  wire sync_lvl = ext_sel_q ? fsync_s[1] : (frm_cnt_q < BIT_DIV);

  // ************************************************************
  // receive and word processing
  // ************************************************************
  reg  [7:0] rx_sh_q;
  reg  [3:0] rx_cnt_q;
  reg        word_vld_q;
  reg  [7:0] word_q;
  wire [7:0] rx_word = {rx_sh_q[6:0], sin_s[1]};

  // through mode hands the word on untouched, negative zero included; in
  // normal mode with center clip latched on a quiet word is clipped to the smallest positive code and
  // negative zero is folded onto positive zero
  function [7:0] ecc_process;
    input [7:0] w;
    input       thru;
    input       clip;
    begin
      if (thru)
        ecc_process = w;
      else if (clip && (~w[6:0] < `ECC_CLIP_MAG))
        ecc_process = `ECC_MIN_POS_CODE;
      else if (w == `ECC_MIN_NEG_CODE)
        ecc_process = `ECC_MIN_POS_CODE;
      else
        ecc_process = w;
    end
  endfunction

  // a word cut short by a new sync is thrown away and restarted, so a
  // glitch on the sync line costs one word rather than shifting all later ones
  // sync high at a sample edge marks the first bit of a word
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_sh_q    <= 8'h00;
      rx_cnt_q   <= 4'h0;
      word_vld_q <= 1'b0;
      word_q     <= 8'h00;
    end else begin
      word_vld_q <= 1'b0;
      if (sample) begin
        if (sync_lvl) begin
          rx_sh_q  <= {7'h00, sin_s[1]};
          rx_cnt_q <= 4'h1;
        end else if (rx_cnt_q != 4'h0 && rx_cnt_q < `ECC_WORD_BITS) begin
          rx_sh_q  <= rx_word;
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == `ECC_WORD_BITS - 1) begin
            word_q     <= ecc_process(rx_word, thru_q, clip_q);
            word_vld_q <= 1'b1;
          end
        end
      end
    end
  end

  // ************************************************************
  // two-entry buffer
  // ************************************************************
  reg  [7:0] buf_mem [0:1];
  reg        buf_wp_q, buf_rp_q;
  reg  [1:0] buf_cnt_q;
  reg        ovr_q;
  wire       buf_in_rdy  = (buf_cnt_q != 2'h2);
  wire       buf_out_vld = (buf_cnt_q != 2'h0);
  wire       tx_start;
  wire       buf_push    = word_vld_q & buf_in_rdy;
  wire       buf_pop     = tx_start & buf_out_vld;
  wire       ovr_clr     = wr_en && addr == `ECC_REG_STATUS && wr_data[`ECC_ST_OVR_BIT];

  // two entries let a finished word wait while the previous one is still
  // being shifted out; with one word in and one out per frame it never
  // fills, so the overrun flag points at a timing fault on the link
  // a word that finds the buffer full is counted as overrun; set wins over clear
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      buf_wp_q   <= 1'b0;
      buf_rp_q   <= 1'b0;
      buf_cnt_q  <= 2'h0;
      ovr_q      <= 1'b0;
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp_q] <= word_q;
        buf_wp_q          <= ~buf_wp_q;
      end
      if (buf_pop)
        buf_rp_q <= ~buf_rp_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
      if (word_vld_q && !buf_in_rdy)
        ovr_q <= 1'b1;
      else if (ovr_clr)
        ovr_q <= 1'b0;
    end
  end

  // ************************************************************
  // transmit
  // ************************************************************
  reg  [7:0] tx_sh_q;
  reg  [3:0] tx_cnt_q;
  // serializer takes a word only when idle at the start of a frame
  assign tx_start = launch & sync_lvl & (tx_cnt_q == 4'h0);

  // msb goes out with the load, the other seven on the next launch edges;
  // the enable drops at the ninth launch edge, so the line is released
  // for the rest of the frame and a partner may share the time slots
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_sh_q          <= 8'h00;
      tx_cnt_q         <= 4'h0;
      send_output_q    <= 1'b0;
      send_output_oe_q <= 1'b0;
    end else if (buf_pop) begin
      tx_sh_q          <= {buf_mem[buf_rp_q][6:0], 1'b0};
      send_output_q    <= buf_mem[buf_rp_q][7];
      send_output_oe_q <= 1'b1;
      tx_cnt_q         <= 4'h1;
    end else if (launch && tx_cnt_q != 4'h0) begin
      if (tx_cnt_q == `ECC_WORD_BITS) begin
        tx_cnt_q         <= 4'h0;
        send_output_oe_q <= 1'b0;
        send_output_q    <= 1'b0;
      end else begin
        send_output_q <= tx_sh_q[7];
        tx_sh_q       <= {tx_sh_q[6:0], 1'b0};
        tx_cnt_q      <= tx_cnt_q + 4'h1;
      end
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  // timing source select; switching it in mid frame may spoil one word
  // in each direction, so software should change it while the link is quiet
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      ext_sel_q <= 1'b0;
    else if (wr_en && addr == `ECC_REG_CTRL)
      ext_sel_q <= wr_data[`ECC_CTRL_EXT_BIT];
  end

  // read data are registered, so they stand in the cycle after the strobe
  // and hold until the next read; there is never a wait state
  // unmapped addresses read as zero
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      rd_data_q <= 8'h00;
    else if (rd_en) begin
      case (addr)
        `ECC_REG_CTRL:   rd_data_q <= {7'h00, ext_sel_q};
        `ECC_REG_STATUS: rd_data_q <= {3'h0, howl_detect_active_q, ovr_q, hdis_q, thru_q, clip_q};
        `ECC_REG_LAST:   rd_data_q <= word_q;
        default:         rd_data_q <= 8'h00;
      endcase
    end
  end

endmodule

// file: test/ecc_ctrl_sva.sv
`timescale 1ns/1ps
// ************************************************************
// timing and control checks
// ************************************************************
module ecc_ctrl_sva #(
  parameter BIT_DIV   = 75,
  parameter BIT_HIGH  = 37,
  parameter FRAME_DIV = 2400
) (
  input wire       sys_clk,              // basic clock
  input wire       nrst,                 // async reset
  input wire [3:0] addr,                 // register address
  input wire       rd_en,                // read strobe
  input wire [7:0] rd_data_q,            // read data
  input wire       latch_strobe_n,       // latch strobe
  input wire       howl_detect_disable,  // control pin
  input wire       bit_clock_output_q,   // bit clock
  input wire       frame_sync_output_q,  // frame sync
  input wire       howl_detect_active_q, // detector on
  input wire       master_clock_output   // buffered clock
);
  reg  [15:0] bc_q;
  reg  [15:0] fc_q;
  reg         bp_q;
  reg         fp_q;
  reg         bs_q;
  reg         fs_q;
  wire        b_rise = bit_clock_output_q & ~bp_q;
  wire        f_rise = frame_sync_output_q & ~fp_q;
  // cycles since last rise; the first rise after reset has no history
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {bc_q, fc_q, bp_q, fp_q, bs_q, fs_q} <= 0;
    end else begin
      bp_q <= bit_clock_output_q;
      fp_q <= frame_sync_output_q;
      bc_q <= b_rise ? 16'h0001 : bc_q + 16'h0001;
      fc_q <= f_rise ? 16'h0001 : fc_q + 16'h0001;
      bs_q <= bs_q | b_rise;
      fs_q <= fs_q | f_rise;
    end
  end
  bit_period_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    b_rise && bs_q |-> bc_q == 16'(BIT_DIV)) else $error("bit clock period wrong");
  bit_high_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !bit_clock_output_q && bp_q |-> bc_q == 16'(BIT_HIGH)) else $error("bit clock high time wrong");
  frame_period_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    f_rise && fs_q |-> fc_q == 16'(FRAME_DIV)) else $error("frame period wrong");
  frame_high_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !frame_sync_output_q && fp_q |-> fc_q == 16'(BIT_DIV)) else $error("frame sync width wrong");
  mclk_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !master_clock_output) else $error("master clock not following");
  mclk_high_a: assert property (@(negedge sys_clk) disable iff (!nrst)
    master_clock_output) else $error("master clock not following");
  howl_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(howl_detect_active_q) |-> !$past(latch_strobe_n, 3)
      && howl_detect_active_q == !$past(howl_detect_disable, 3)) else $error("howl enable moved wrongly");
  unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rd_en && addr > 4'h2 |=> rd_data_q == 8'h00) else $error("unmapped read not zero");
endmodule
bind ecc_ctrl ecc_ctrl_sva #(.BIT_DIV(BIT_DIV), .BIT_HIGH(BIT_HIGH), .FRAME_DIV(FRAME_DIV)) u_sva (
  .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .rd_en(rd_en), .rd_data_q(rd_data_q),
  .latch_strobe_n(latch_strobe_n), .howl_detect_disable(howl_detect_disable),
  .bit_clock_output_q(bit_clock_output_q), .frame_sync_output_q(frame_sync_output_q),
  .howl_detect_active_q(howl_detect_active_q), .master_clock_output(master_clock_output));

// file: test/ecc_codec_model.sv
`timescale 1ns/1ps
// ************************************************************
// pcm codec on the serial side
// ************************************************************
module ecc_codec_model (
  input  wire        sys_clk,             // basic clock
  input  wire        ext,                 // follow own link clocks
  input  wire [7:0]  tx_word,             // word sent each frame
  input  wire        bit_clock_output_q,  // generated bit clock
  input  wire        frame_sync_output_q, // generated frame sync
  input  wire        send_output_q,       // serial out of block
  input  wire        send_output_oe_q,    // its enable
  output reg         ext_bit_clock,       // own bit clock
  output reg         ext_frame_sync,      // own frame sync
  output reg         send_input,          // serial in of block
  output reg  [7:0]  rx_word,             // last word received
  output reg  [15:0] rx_n                 // words received
);
  reg  [3:0] eb_q;
  reg  [7:0] sh_q;
  reg  [7:0] rx_q;
  reg  [2:0] n_q;
  reg  [2:0] rc_q;
  reg        pb_q;
  wire       b = ext ? ext_bit_clock : bit_clock_output_q;
  wire       f = ext ? ext_frame_sync : frame_sync_output_q;
  // free running 400 ns link clock, phase unrelated to sys_clk
  initial begin
    {ext_bit_clock, ext_frame_sync, send_input, eb_q, sh_q, rx_q, n_q, rc_q, pb_q} = 0;
    {rx_word, rx_n} = 0;
    #137;
    forever #200 ext_bit_clock = ~ext_bit_clock;
  end
  // one frame of twelve bits, sync high for the first
  always @(posedge ext_bit_clock) begin
    eb_q <= (eb_q == 4'hB) ? 4'h0 : eb_q + 4'h1;
    ext_frame_sync <= (eb_q == 4'hB);
  end
  // launch on rising bit clock, capture on falling, msb first
  always @(posedge sys_clk) begin
    pb_q <= b;
    if (b && !pb_q) begin
      if (f) begin
        send_input <= tx_word[7];
        sh_q <= {tx_word[6:0], 1'b0};
        n_q <= 3'h7;
      end else if (n_q != 3'h0) begin
        send_input <= sh_q[7];
        sh_q <= sh_q << 1;
        n_q <= n_q - 3'h1;
      end else begin
        send_input <= ~send_input; // no pull on the line, so never a steady stale bit
      end
    end
    if (!send_output_oe_q) begin
      rc_q <= 3'h0;
    end else if (!b && pb_q) begin
      rx_q <= {rx_q[6:0], send_output_q};
      rc_q <= rc_q + 3'h1;
      if (rc_q == 3'h7) begin
        rx_word <= {rx_q[6:0], send_output_q};
        rx_n <= rx_n + 16'h0001;
      end
    end
  end
endmodule

// file: test/test_echo_canceler_control_sync.sv
`timescale 1ns/1ps
`include "ecc_map.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin n_fail = n_fail + 1; \
  $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
// ************************************************************
// bench top
// ************************************************************
module test_echo_canceler_control_sync;
  reg         sys_clk, nrst, wr_en, rd_en, clip, thru, hdis, strobe_n, ext;
  reg  [3:0]  addr;
  reg  [7:0]  wr_data, tx_word, rv;
  reg  [23:0] cs [0:5];
  wire [7:0]  rd_data_q, rx_word;
  wire [15:0] rx_n;
  wire        ebc, efs, sin, so, oe, bco, fso, hact, mco;
  integer     n_fail, checks, i;
  ecc_ctrl #(.BIT_DIV(15), .BIT_HIGH(7), .FRAME_DIV(180)) DUT (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .center_clip_enable(clip),
    .through_mode_select(thru), .howl_detect_disable(hdis), .latch_strobe_n(strobe_n), .ext_bit_clock(ebc),
    .ext_frame_sync(efs), .send_input(sin), .send_output_q(so), .send_output_oe_q(oe), .bit_clock_output_q(bco),
    .frame_sync_output_q(fso), .howl_detect_active_q(hact), .master_clock_output(mco));
  ecc_codec_model u_codec (.sys_clk(sys_clk), .ext(ext), .tx_word(tx_word), .bit_clock_output_q(bco),
    .frame_sync_output_q(fso), .send_output_q(so), .send_output_oe_q(oe), .ext_bit_clock(ebc),
    .ext_frame_sync(efs), .send_input(sin), .rx_word(rx_word), .rx_n(rx_n));
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  task tick(input integer n); repeat (n) @(posedge sys_clk); endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge sys_clk); addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge sys_clk); wr_en <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task rd(input [3:0] a, output [7:0] d);
    @(posedge sys_clk); addr <= a; rd_en <= 1'b1;
    @(posedge sys_clk); rd_en <= 1'b0;
    #1 d = rd_data_q;
  endtask
  task wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // pins settle before the strobe, which is held long enough to be seen
  task run(input integer k);
    integer lim;
    reg [15:0] s;
    @(posedge sys_clk); {thru, clip, hdis} <= cs[k][18:16]; tx_word <= cs[k][15:8];
    tick(2); strobe_n <= 1'b0; tick(6); strobe_n <= 1'b1;
    s = rx_n; lim = 0;
    while (rx_n - s < 3 && lim < 3000) begin @(posedge sys_clk); lim = lim + 1; end
    if (lim >= 3000) begin n_fail = n_fail + 1; $display("mismatch at %0t: got %0h expected %0h", $time, lim, 0); wrap_up; end
    `CHK(rx_word, cs[k][7:0])
    rd(`ECC_REG_LAST, rv); `CHK(rv, cs[k][7:0])
    rd(`ECC_REG_STATUS, rv); `CHK(rv & 8'h1F, {3'h0, ~cs[k][16], 1'b0, cs[k][16], cs[k][18], cs[k][17]})
    `CHK(hact, ~cs[k][16])
    $display("case %0d ext %0d done", k, ext);
  endtask
  initial begin
    {nrst, wr_en, rd_en, clip, thru, hdis, ext, addr, wr_data, tx_word} = 0;
    strobe_n = 1'b1; n_fail = 0; checks = 0;
    // flags {thru, clip, hdis}, sent word, expected word
    cs[0] = 24'h047F7F; cs[1] = 24'h007FFF; cs[2] = 24'h03F5FF;
    cs[3] = 24'h028080; cs[4] = 24'h01F5F5; cs[5] = 24'h07F5F5;
    tick(4); nrst <= 1'b1;
    rd(`ECC_REG_CTRL, rv); `CHK(rv, 8'h00)
    rd(`ECC_REG_STATUS, rv); `CHK(rv, 8'h10)
    $display("reset test done");
    for (i = 0; i < 6; i = i + 1) run(i);
    // pins move without a strobe: latched state must not follow
    @(posedge sys_clk); {thru, clip, hdis} <= 3'h0; tick(40);
    rd(`ECC_REG_STATUS, rv); `CHK(rv & 8'h1F, 8'h07)
    `CHK(hact, 1'b0)
    wr(4'h9, 8'hFF); rd(4'h9, rv); `CHK(rv, 8'h00)
    rd(`ECC_REG_CTRL, rv); `CHK(rv, 8'h00)
    $display("hold and unmapped test done");
    // external link clocks, as needed off the nominal basic clock
    wr(`ECC_REG_CTRL, 8'h01); rd(`ECC_REG_CTRL, rv); `CHK(rv, 8'h01)
    ext <= 1'b1;
    run(0); run(2);
    wrap_up;
  end
endmodule
